// *** logic/pll_ctrl_map.svh ***
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH
// Register byte offsets
`define OFS_LOOP_ENABLE 8'h40
`define OFS_LOOP_SETUP 8'h4C
`define OFS_STATE_REPORT 8'h50
`define OFS_IRQ_STATUS 8'h54
`define OFS_IRQ_CLEAR 8'h58
`define OFS_IRQ_ENABLE 8'h5C
// Reset values and writable bits
`define SETUP_RESET 32'h0000_0000
`define SETUP_WR_MASK 32'h07FF_173F
`define STATE_RESET 8'h00
// Loop setup field positions
`define F_DIV_MSB 26
`define F_DIV_LSB 16
`define F_BYPASS 12
`define F_LOCK_WAIT_LIMIT_MSB 10
`define F_LOCK_WAIT_LIMIT_LSB 8
`define F_REFSEL_MSB 5
`define F_REFSEL_LSB 4
`define F_WUF 3
`define F_LOW_POWER_PHASE_DETECT 2
`define F_FILT_MSB 1
`define F_FILT_LSB 0
// State report bit positions
`define ST_DIV 3
`define ST_EN 2
`define ST_RDY 1
`define ST_LOCK 0
// Interrupt bit positions
`define IRQ_LOCK 0
`define IRQ_UNLOCK 1
`define IRQ_TIMEOUT 2
`define IRQ_READY 3
`define IRQ_WIDTH 4
// Timing
`define CLK_PERIOD_NS 4
`define MS_NS 1000000
`define STARTUP_NS 1000
`define EN_SETTLE_CYCLES 4
`define LOCK_WAIT_LIMIT_FIRST_MS 8
`endif

// *** logic/pll_ctrl_pkg.sv ***
`default_nettype none
`include "pll_ctrl_map.svh"
package pll_ctrl_pkg;
	// Loop sequencing states
	typedef enum logic [2:0]
	{
		ST_OFF = 3'b000,
		ST_ENABLING = 3'b001,
		ST_STARTUP = 3'b010,
		ST_LOCKWAIT = 3'b011,
		ST_RUN = 3'b100,
		ST_TIMEOUT = 3'b101,
		ST_DISABLING = 3'b110
	} loop_state_e;
	// Reference source codes
	typedef enum logic [1:0]
	{
		REF_FIRST = 2'b00,
		REF_SECOND = 2'b01,
		REF_GENERIC = 2'b10,
		REF_RSVD = 2'b11
	} ref_sel_e;
	// Loop filter codes
	typedef enum logic [1:0]
	{
		FILT_DEFAULT = 2'b00,
		FILT_NARROW = 2'b01,
		FILT_WIDE = 2'b10,
		FILT_DAMP = 2'b11
	} filter_e;
	typedef logic [`IRQ_WIDTH-1:0] irq_t;
endpackage
`default_nettype wire

// *** logic/pll_prescaler.sv ***
`default_nettype none
module pll_prescaler import pll_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Control
	input wire logic i_run,
	input wire logic [10:0] i_factor,
	// Reference in, divided out
	input wire logic i_ref_level,
	output logic o_div_clk
);
	logic ref_prev_reg;
	logic [10:0] cnt_reg;
	logic rise;

	// Sampled edge of the second reference
	assign rise = i_ref_level & ~ref_prev_reg;
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			ref_prev_reg <= 1'b0;
		else if (i_clk_en)
			ref_prev_reg <= i_ref_level;
	end

	// Half period is factor+1 edges; >= keeps a shrunk factor from hanging
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_reg <= 11'h000;
			o_div_clk <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!i_run)
			begin
				cnt_reg <= 11'h000;
				o_div_clk <= 1'b0;
			end
			else if (rise)
			begin
				if (cnt_reg >= i_factor)
				begin
					cnt_reg <= 11'h000;
					o_div_clk <= ~o_div_clk;
				end
				else
					cnt_reg <= cnt_reg + 11'h001;
			end
		end
	end

	AST_PRESC_TOGGLE: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_clk_en && i_run && rise && cnt_reg < i_factor
		|=> $stable(o_div_clk))
	else $error("prescaler toggled before factor+1 edges");
endmodule
`default_nettype wire

// *** logic/pll_control_status.sv ***
// Behaviour
// - Prescaler divides second reference by 2x(factor+1)
// - Gated clock stops without lock unless bypassed, or with quick wakeup before the first lock
// - Lock timeout: 0 none, 4..7 give 8..11ms
// - Source select: first, second, generic, reserved
// - Quick wakeup opens gate after startup only
// - Low power bit deselects time-to-digital converter
// - Filter field picks default, narrow, wide, damped
// - Status bit 3 shows prescaler active
// - Status bit 2 shows loop really enabled
// - Status bit 1 shows sequencer in run state
// - Status bit 0 shows current lock
// - Reserved bits read zero, written zero
// - Enable change takes cycles; poll status
`default_nettype none
`include "pll_ctrl_map.svh"
module pll_control_status import pll_ctrl_pkg::*;
#(
	parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
)
(
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// AXI4-Lite write
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Loop side
	input wire logic i_first_reference_clock,
	input wire logic i_second_reference_clock,
	input wire logic i_generic_reference_clock,
	input wire logic i_loop_clock,
	input wire logic i_lock,
	output logic o_selected_reference,
	output logic o_loop_enable,
	output logic o_tdc_select,
	output logic [1:0] o_filter_select,
	output logic o_gated_output_clock,
	output logic o_irq
);
	localparam int STARTUP_CYC =
		(`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam logic [31:0] SETTLE_LAST = 32'(`EN_SETTLE_CYCLES - 1);
	localparam logic [31:0] STARTUP_LAST = 32'(STARTUP_CYC - 1);

	logic enable_reg;
	logic [31:0] setup_reg;
	irq_t irq_status_reg;
	irq_t irq_enable_reg;
	irq_t irq_event;
	loop_state_e state_reg;
	loop_state_e state_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic [31:0] lock_limit;
	logic en_reg;
	logic rdy_reg;
	logic lock_reg;
	logic locked_once_reg;
	logic presc_run;
	logic div_clk;
	logic gate_open;
	logic [7:0] state_report;
	logic aw_got_reg;
	logic w_got_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic rvalid_reg;
	logic do_write;
	logic [31:0] rd_data;
	logic rd_err;
	logic wr_err;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus slave: address and data may come in either order
	assign o_awready = i_clk_en & ~aw_got_reg & ~bvalid_reg;
	assign o_wready = i_clk_en & ~w_got_reg & ~bvalid_reg;
	assign o_bvalid = i_clk_en & bvalid_reg;
	assign o_arready = i_clk_en & ~rvalid_reg;
	assign o_rvalid = i_clk_en & rvalid_reg;
	assign do_write = aw_got_reg & w_got_reg & ~bvalid_reg;

	// Write capture and response
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			o_bresp <= 2'b00;
		end
		else if (i_clk_en)
		begin
			if (o_awready && i_awvalid)
			begin
				aw_got_reg <= 1'b1;
				waddr_reg <= i_awaddr;
			end
			if (o_wready && i_wvalid)
			begin
				w_got_reg <= 1'b1;
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (do_write)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				o_bresp <= wr_err ? 2'b10 : 2'b00;
			end
			else if (bvalid_reg && i_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Unmapped write address answers SLVERR
	always_comb
	begin
		wr_err = 1'b0;
		if ({waddr_reg[7:2], 2'b00} == `OFS_LOOP_ENABLE)
			wr_err = 1'b0;
		else if ({waddr_reg[7:2], 2'b00} == `OFS_LOOP_SETUP)
			wr_err = 1'b0;
		else if ({waddr_reg[7:2], 2'b00} == `OFS_STATE_REPORT)
			wr_err = 1'b0;
		else if ({waddr_reg[7:2], 2'b00} == `OFS_IRQ_STATUS)
			wr_err = 1'b0;
		else if ({waddr_reg[7:2], 2'b00} == `OFS_IRQ_CLEAR)
			wr_err = 1'b0;
		else if ({waddr_reg[7:2], 2'b00} == `OFS_IRQ_ENABLE)
			wr_err = 1'b0;
		else
			wr_err = 1'b1;
	end

	// Read decode; reserved bits and write-only words read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if ({i_araddr[7:2], 2'b00} == `OFS_LOOP_ENABLE)
			rd_data = {31'h0000_0000, enable_reg};
		else if ({i_araddr[7:2], 2'b00} == `OFS_LOOP_SETUP)
			rd_data = setup_reg & `SETUP_WR_MASK;
		else if ({i_araddr[7:2], 2'b00} == `OFS_STATE_REPORT)
			rd_data = {24'h00_0000, state_report};
		else if ({i_araddr[7:2], 2'b00} == `OFS_IRQ_STATUS)
			rd_data = {28'h000_0000, irq_status_reg};
		else if ({i_araddr[7:2], 2'b00} == `OFS_IRQ_CLEAR)
			rd_data = 32'h0000_0000;
		else if ({i_araddr[7:2], 2'b00} == `OFS_IRQ_ENABLE)
			rd_data = {28'h000_0000, irq_enable_reg};
		else
			rd_err = 1'b1;
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rvalid_reg <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= 2'b00;
		end
		else if (i_clk_en)
		begin
			if (o_arready && i_arvalid)
			begin
				rvalid_reg <= 1'b1;
				o_rdata <= rd_data;
				o_rresp <= rd_err ? 2'b10 : 2'b00;
			end
			else if (rvalid_reg && i_rready)
				rvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; reserved bits never stored
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			enable_reg <= 1'b0;
			setup_reg <= `SETUP_RESET;
			irq_enable_reg <= '0;
		end
		else if (i_clk_en && do_write)
		begin
			if ({waddr_reg[7:2], 2'b00} == `OFS_LOOP_ENABLE && wstrb_reg[0])
				enable_reg <= wdata_reg[0];
			else if ({waddr_reg[7:2], 2'b00} == `OFS_LOOP_SETUP)
				setup_reg <= merge(setup_reg, wdata_reg, wstrb_reg) &
					`SETUP_WR_MASK;
			else if ({waddr_reg[7:2], 2'b00} == `OFS_IRQ_ENABLE &&
				wstrb_reg[0])
				irq_enable_reg <= wdata_reg[`IRQ_WIDTH-1:0];
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			irq_status_reg <= '0;
		else if (i_clk_en)
		begin
			if (do_write && wstrb_reg[0] &&
				{waddr_reg[7:2], 2'b00} == `OFS_IRQ_CLEAR)
				irq_status_reg <= (irq_status_reg &
					~wdata_reg[`IRQ_WIDTH-1:0]) | irq_event;
			else
				irq_status_reg <= irq_status_reg | irq_event;
		end
	end
	assign o_irq = |(irq_status_reg & irq_enable_reg);

	////////////////////////////////////////////////////////////////////////
	// Lock wait limit: top bit set means 8..11 ms, else none
	assign lock_limit = 32'(`LOCK_WAIT_LIMIT_FIRST_MS +
		int'(setup_reg[`F_LOCK_WAIT_LIMIT_LSB +: 2])) * 32'(MS_CYCLES);

	// Enable settle, startup, lock wait, run and disable sequence
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg + 32'h0000_0001;
		case (state_reg)
			ST_OFF:
			begin
				cnt_next = 32'h0000_0000;
				if (enable_reg)
					state_next = ST_ENABLING;
			end
			ST_ENABLING:
			begin
				if (!enable_reg)
				begin
					state_next = ST_DISABLING;
					cnt_next = 32'h0000_0000;
				end
				else if (cnt_reg == SETTLE_LAST)
				begin
					state_next = ST_STARTUP;
					cnt_next = 32'h0000_0000;
				end
			end
			ST_STARTUP:
			begin
				if (!enable_reg)
				begin
					state_next = ST_DISABLING;
					cnt_next = 32'h0000_0000;
				end
				else if (cnt_reg == STARTUP_LAST)
				begin
					cnt_next = 32'h0000_0000;
					state_next = setup_reg[`F_WUF] ? ST_RUN : ST_LOCKWAIT;
				end
			end
			ST_LOCKWAIT:
			begin
				if (!enable_reg)
				begin
					state_next = ST_DISABLING;
					cnt_next = 32'h0000_0000;
				end
				else if (lock_reg)
					state_next = ST_RUN;
				else if (setup_reg[`F_LOCK_WAIT_LIMIT_MSB] &&
					cnt_reg == lock_limit - 32'h0000_0001)
					state_next = ST_TIMEOUT;
			end
			ST_RUN, ST_TIMEOUT:
			begin
				cnt_next = 32'h0000_0000;
				if (!enable_reg)
					state_next = ST_DISABLING;
			end
			ST_DISABLING:
			begin
				if (cnt_reg == SETTLE_LAST)
					state_next = ST_OFF;
			end
			default:
			begin
				state_next = ST_OFF;
				cnt_next = 32'h0000_0000;
			end
		endcase
	end

	// Sequencer state and registered status
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= ST_OFF;
			cnt_reg <= 32'h0000_0000;
			en_reg <= 1'b0;
			rdy_reg <= 1'b0;
			lock_reg <= 1'b0;
			locked_once_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			en_reg <= state_next != ST_OFF && state_next != ST_ENABLING;
			rdy_reg <= state_next == ST_RUN;
			lock_reg <= i_lock;
			locked_once_reg <= rdy_reg & (locked_once_reg | lock_reg);
		end
	end

	// Events feeding the sticky status
	always_comb
	begin
		irq_event = '0;
		irq_event[`IRQ_LOCK] = i_lock & ~lock_reg;
		irq_event[`IRQ_UNLOCK] = ~i_lock & lock_reg & en_reg;
		irq_event[`IRQ_TIMEOUT] = state_reg == ST_LOCKWAIT &&
			state_next == ST_TIMEOUT;
		irq_event[`IRQ_READY] = state_reg != ST_RUN && state_next == ST_RUN;
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler runs only when the second reference is chosen
	assign presc_run = en_reg &&
		setup_reg[`F_REFSEL_MSB:`F_REFSEL_LSB] == REF_SECOND;

	pll_prescaler u_prescaler
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_run(presc_run),
		.i_factor(setup_reg[`F_DIV_MSB:`F_DIV_LSB]),
		.i_ref_level(i_second_reference_clock),
		.o_div_clk(div_clk)
	);

	// Quick wakeup holds the gate open only until the first lock
	assign gate_open = rdy_reg & (setup_reg[`F_BYPASS] | lock_reg |
		(setup_reg[`F_WUF] & ~locked_once_reg));

	// Loop-side outputs, all from flops
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_selected_reference <= 1'b0;
			o_loop_enable <= 1'b0;
			o_tdc_select <= 1'b1; // Low power bit resets clear
			o_filter_select <= FILT_DEFAULT;
			o_gated_output_clock <= 1'b0;
		end
		else if (i_clk_en)
		begin
			case (ref_sel_e'(setup_reg[`F_REFSEL_MSB:`F_REFSEL_LSB]))
				REF_FIRST: o_selected_reference <= i_first_reference_clock;
				REF_SECOND: o_selected_reference <= div_clk;
				REF_GENERIC: o_selected_reference <= i_generic_reference_clock;
				default: o_selected_reference <= 1'b0;
			endcase
			o_loop_enable <= state_next != ST_OFF;
			o_tdc_select <= ~setup_reg[`F_LOW_POWER_PHASE_DETECT];
			o_filter_select <= setup_reg[`F_FILT_MSB:`F_FILT_LSB];
			o_gated_output_clock <= i_loop_clock & gate_open;
		end
	end

	// Status word; upper bits stay zero
	assign state_report = {4'h0, presc_run, en_reg, rdy_reg, lock_reg};

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	AST_GATE_LOCK: assert property (
		i_clk_en && !setup_reg[`F_BYPASS] && !lock_reg &&
		!(setup_reg[`F_WUF] && !locked_once_reg)
		|=> !o_gated_output_clock)
	else $error("gated clock ran without lock or bypass");
	AST_NO_TIMEOUT: assert property (
		state_reg == ST_LOCKWAIT && !setup_reg[`F_LOCK_WAIT_LIMIT_MSB]
		|=> state_reg != ST_TIMEOUT)
	else $error("timeout taken with no limit set");
	AST_SRC_MUX: assert property (
		i_clk_en && setup_reg[`F_REFSEL_MSB:`F_REFSEL_LSB] == REF_FIRST
		&& $stable(setup_reg)
		|=> o_selected_reference == $past(i_first_reference_clock))
	else $error("first reference not passed through");
	AST_QUICK_WAKE: assert property (
		i_clk_en && enable_reg && state_reg == ST_STARTUP &&
		cnt_reg == STARTUP_LAST && setup_reg[`F_WUF]
		|=> state_reg == ST_RUN ##1 rdy_reg)
	else $error("quick wakeup did not open after startup");
	AST_TDC_SEL: assert property (
		i_clk_en ##1 $stable(setup_reg) |-> o_tdc_select == !setup_reg[`F_LOW_POWER_PHASE_DETECT])
	else $error("converter select disagrees with low power bit");
	AST_RSVD_ZERO: assert property (
		(setup_reg & ~`SETUP_WR_MASK) == 32'h0000_0000)
	else $error("reserved setup bit stored");
	AST_EN_STATUS: assert property (
		i_clk_en && state_reg == ST_OFF && enable_reg
		|=> !state_report[`ST_EN] [*4])
	else $error("enable reported before settling");
	AST_PRESC_BIT: assert property (
		state_report[`ST_DIV] |-> en_reg &&
		setup_reg[`F_REFSEL_MSB:`F_REFSEL_LSB] == REF_SECOND)
	else $error("prescaler bit without second reference");
	AST_TIMEOUT_RDY: assert property (
		i_clk_en && state_reg == ST_LOCKWAIT && state_next == ST_TIMEOUT
		|=> irq_status_reg[`IRQ_TIMEOUT] && !state_report[`ST_RDY])
	else $error("timeout not recorded or ready set");
	AST_LOCK_BIT: assert property (
		i_clk_en |=> state_report[`ST_LOCK] == $past(i_lock))
	else $error("lock bit does not follow lock input");

	COV_RUN: cover property (state_reg == ST_LOCKWAIT ##1 state_reg == ST_RUN);
	COV_TIMEOUT: cover property (state_reg == ST_TIMEOUT);
	COV_GATED: cover property ($rose(o_gated_output_clock));
	COV_WRITE: cover property (o_bvalid && i_bready);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
`include "pll_ctrl_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pll_ctrl_pkg::*;
	localparam int MS = 40;
	logic clk = 0;
	logic rst = 1;
	logic aw_v = 0;
	logic w_v = 0;
	logic b_r = 0;
	logic ar_v = 0;
	logic r_r = 0;
	logic [7:0] aw_a = 0;
	logic [7:0] ar_a = 0;
	logic [31:0] w_d = 0;
	logic ref0 = 0;
	logic ref1 = 0;
	logic gref = 0;
	logic lclk = 0;
	logic lock = 0;
	logic ce = 1;
	logic awready, wready, bvalid, arready, rvalid, selref, loop_en, tdc;
	logic gclk, irq;
	logic [1:0] bresp, rresp, filt;
	logic [31:0] rdata, rq, v;
	logic [65:0] e;
	logic [65:0] exp_q[$];
	logic [1:0] expb_q[$];
	int fail_count = 0;
	int num_checks = 0;
	int seed = 70;
	int cyc = 0;
	int c, n;

	pll_control_status #(.MS_CYCLES(MS)) dut_u (.i_ref_clk(clk), .i_rst(rst),
		.i_clk_en(ce), .i_awaddr(aw_a), .i_awvalid(aw_v),
		.o_awready(awready), .i_wdata(w_d), .i_wstrb(4'hF), .i_wvalid(w_v),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(b_r), .i_araddr(ar_a), .i_arvalid(ar_v),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(r_r), .i_first_reference_clock(ref0),
		.i_second_reference_clock(ref1), .i_generic_reference_clock(gref),
		.i_loop_clock(lclk), .i_lock(lock), .o_selected_reference(selref),
		.o_loop_enable(loop_en), .o_tdc_select(tdc),
		.o_filter_select(filt), .o_gated_output_clock(gclk), .o_irq(irq));

	////////////////////////////////////////////////////////////////////////
	// Clock; oscillator and second reference stand-ins, hang guard
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		lclk <= ~lclk;
		ref1 <= cyc[1]; // Four-cycle period so the divider sees clean edges
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad("timeout");
			print_verdict();
		end
	end

	task automatic bad(input string m);
		fail_count++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input string m);
		num_checks++;
		if (g !== x)
			bad(m);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Results watched mid-cycle, where every output has settled
	always @(negedge clk)
	begin
		if (bvalid === 1'b1 && b_r)
			if (expb_q.size() == 0)
				bad("unexpected write response");
			else
				chk(32'(bresp), 32'(expb_q.pop_front()), "bresp");
		if (rvalid === 1'b1 && r_r)
			if (exp_q.size() == 0)
				bad("unexpected read data");
			else
			begin
				e = exp_q.pop_front();
				chk(rdata & e[65:34], e[33:2], "rdata");
				chk(32'(rresp), 32'(e[1:0]), "rresp");
			end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus master; ready is looked at mid-cycle, which equals its edge value
	// Response readies stay high once raised, so no answer is ever refused
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ah, wh, ad, wd;
		ad = 0;
		wd = 0;
		expb_q.push_back(r);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1;
		w_v <= 1;
		b_r <= 1;
		do
		begin
			@(negedge clk);
			ah = aw_v & awready;
			wh = w_v & wready;
			@(posedge clk);
			if (ah)
				aw_v <= 0;
			if (wh)
				w_v <= 0;
			ad |= ah;
			wd |= wh;
		end while (!(ad && wd));
		do
		begin
			@(negedge clk);
			ah = bvalid;
			@(posedge clk);
		end while (!ah);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m, input logic [1:0] r);
		logic h;
		exp_q.push_back({m, x, r});
		ar_a <= a;
		ar_v <= 1;
		r_r <= 1;
		do
		begin
			@(negedge clk);
			h = arready;
			@(posedge clk);
		end while (!h);
		ar_v <= 0;
		do
		begin
			@(negedge clk);
			h = rvalid;
			rq = rdata;
			@(posedge clk);
		end while (!h);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		rd(a, x, 32'hFFFF_FFFF, 2'b00);
	endtask

	// Software must poll, the switch takes an unstated few cycles
	task automatic poll_en(input logic x);
		int k;
		k = 0;
		do
		begin
			rd(`OFS_STATE_REPORT, 32'h0000_0000, 32'h0000_0000, 2'b00);
			k++;
		end while (rq[`ST_EN] !== x && k < 100);
		chk(32'(rq[`ST_EN]), 32'(x), "enable status");
	endtask

	task automatic loop_off();
		wr(`OFS_LOOP_ENABLE, 32'h0000_0000, 2'b00);
		poll_en(1'b0);
		chk(32'(loop_en), 32'h0000_0000, "loop enable off");
	endtask

	// Rising edges of the gated clock (w=0) or selected reference (w=1)
	task automatic cnt(input bit w, input int k, output int q);
		logic p, s;
		q = 0;
		p = 1;
		repeat (k)
		begin
			@(negedge clk);
			s = w ? selref : gclk;
			if (s && !p)
				q++;
			p = s;
		end
		@(posedge clk);
	endtask

	function automatic logic [31:0] su(input int dv, input int lt,
		input int rs, input logic bp, input logic wf);
		return {5'h00, dv[10:0], 3'h0, bp, 1'b0, lt[2:0], 2'h0, rs[1:0],
			wf, 3'h0};
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		// Reset values, unmapped place, read-only status
		rc(`OFS_LOOP_SETUP, `SETUP_RESET);
		rc(`OFS_STATE_REPORT, 32'h0000_0000);
		rd(8'h60, 32'h0000_0000, 32'hFFFF_FFFF, 2'b10);
		wr(8'h60, 32'h0000_0001, 2'b10);
		wr(`OFS_STATE_REPORT, 32'h0000_000F, 2'b00);
		rc(`OFS_STATE_REPORT, 32'h0000_0000);
		wr(`OFS_LOOP_SETUP, 32'h07FF_173F, 2'b00);
		rc(`OFS_LOOP_SETUP, 32'h07FF_173F);
		// Every filter code, both detector options, random other fields
		for (int f = 0; f < 4; f++)
		begin
			v = ($random(seed) & 32'h07FF_1738) | f | ((f & 1) << 2);
			wr(`OFS_LOOP_SETUP, v, 2'b00);
			rc(`OFS_LOOP_SETUP, v);
			chk(32'(filt), 32'(f), "filter select");
			chk(32'(tdc), 32'(!v[2]), "converter select");
		end
		// Enable on the divided second reference, lock arrives late
		wr(`OFS_IRQ_ENABLE, 32'h0000_000F, 2'b00);
		wr(`OFS_LOOP_SETUP, su(1, 0, 1, 0, 0), 2'b00);
		wr(`OFS_LOOP_ENABLE, 32'h0000_0001, 2'b00);
		poll_en(1'b1);
		chk(32'(loop_en), 32'h0000_0001, "loop enable on");
		repeat (260) @(posedge clk);
		rc(`OFS_STATE_REPORT, 32'h0000_000C);
		cnt(0, 40, c);
		chk(32'(c), 32'h0000_0000, "gate without lock");
		lock <= 1;
		repeat (5) @(posedge clk);
		rc(`OFS_STATE_REPORT, 32'h0000_000F);
		cnt(0, 40, c);
		chk(32'(c >= 15), 32'h0000_0001, "gate with lock");
		rc(`OFS_IRQ_STATUS, 32'h0000_0009);
		chk(32'(irq), 32'h0000_0001, "irq raised");
		wr(`OFS_IRQ_CLEAR, 32'h0000_0009, 2'b00);
		chk(32'(irq), 32'h0000_0000, "irq cleared");
		rc(`OFS_IRQ_STATUS, 32'h0000_0000);
		for (int f = 0; f < 4; f += 3)
		begin
			wr(`OFS_LOOP_SETUP, su(f, 0, 1, 0, 0), 2'b00);
			repeat (20) @(posedge clk);
			cnt(1, 320, c);
			n = 320 / (8 * (f + 1));
			chk(32'(c >= n - 1 && c <= n + 1), 32'h0000_0001, "divide");
		end
		// Bypass keeps the clock running; lock loss seen while masked
		wr(`OFS_IRQ_ENABLE, 32'h0000_0000, 2'b00);
		wr(`OFS_LOOP_SETUP, su(0, 0, 1, 1, 0), 2'b00);
		lock <= 0;
		repeat (5) @(posedge clk);
		rd(`OFS_STATE_REPORT, 32'h0000_000C, 32'h0000_00FD, 2'b00);
		cnt(0, 40, c);
		chk(32'(c >= 15), 32'h0000_0001, "bypass gate");
		// Clock enable low freezes the gate and blocks the bus
		ce <= 0;
		cnt(0, 20, c);
		chk(32'(c), 32'h0000_0000, "frozen gate");
		chk(32'(arready), 32'h0000_0000, "frozen bus");
		ce <= 1;
		chk(32'(irq), 32'h0000_0000, "irq masked");
		rc(`OFS_IRQ_STATUS, 32'h0000_0002);
		wr(`OFS_IRQ_ENABLE, 32'h0000_0002, 2'b00);
		chk(32'(irq), 32'h0000_0001, "irq unmasked");
		wr(`OFS_IRQ_CLEAR, 32'h0000_0002, 2'b00);
		// Quick wakeup on the generic reference, never locked
		loop_off();
		wr(`OFS_LOOP_SETUP, su(0, 0, 2, 0, 1), 2'b00);
		wr(`OFS_LOOP_ENABLE, 32'h0000_0001, 2'b00);
		repeat (270) @(posedge clk);
		rc(`OFS_STATE_REPORT, 32'h0000_0006);
		cnt(0, 40, c);
		chk(32'(c >= 15), 32'h0000_0001, "quick wakeup gate");
		for (int s = 0; s < 4; s += 1 + (s == 0))
		begin
			wr(`OFS_LOOP_SETUP, su(0, 0, s, 0, 1), 2'b00);
			ref0 <= (s != 2);
			gref <= (s != 0);
			repeat (6) @(posedge clk);
			chk(32'(selref), 32'(s != 3), "selected source");
			ref0 <= (s != 0);
			gref <= (s == 0);
			repeat (6) @(posedge clk);
			chk(32'(selref), 32'h0000_0000, "other source");
		end
		// Each lock timeout code, checked just before and after expiry
		for (int t = 4; t < 8; t++)
		begin
			loop_off();
			wr(`OFS_LOOP_SETUP, su(0, t, 0, 0, 0), 2'b00);
			wr(`OFS_IRQ_CLEAR, 32'h0000_000F, 2'b00);
			wr(`OFS_LOOP_ENABLE, 32'h0000_0001, 2'b00);
			repeat (239 + (8 + t - 4) * MS) @(posedge clk);
			rd(`OFS_IRQ_STATUS, 32'h0000_0000, 32'h0000_0004, 2'b00);
			repeat (27) @(posedge clk);
			rd(`OFS_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004, 2'b00);
			rd(`OFS_STATE_REPORT, 32'h0000_0000, 32'h0000_0002, 2'b00);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
